// ### rtl/serial_port_defs.svh
// Purpose: constants for the three-wire serial host port
// Assumes: included by bare name
// Notes: command byte layout is command field [7:5], address field [4:0]
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define CMD_FIELD_MSB 7
`define CMD_FIELD_LSB 5
`define ADDR_FIELD_MSB 4
`define ADDR_FIELD_LSB 0
`define CMD_READ_CTRL 3'h0
`define CMD_WRITE_CTRL 3'h1
`define CMD_READ_RAM 3'h2
`define CMD_WRITE_RAM 3'h3
`define BIT_COUNT_LAST 3'h7
`define BYTE_RESET 8'h00
`define CTRL_BYTES 17
`define RAM_BYTES 32
`endif

// ### rtl/serial_port_pkg.sv
// Purpose: types for the three-wire serial host port
// Assumes: constants live in serial_port_defs.svh
// Notes: none
package serial_port_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] addr_t;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_READ,
    ACC_WRITE
  } access_e;
endpackage : serial_port_pkg

// ### rtl/pin_sync.sv
// Purpose: two-flop synchroniser for the strobe, select and data pins
// Assumes: pins are asynchronous to mclk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins in
  input wire logic [2:0] pin_in,
  // synchronised out
  output logic [2:0] pin_out
);
  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
  end

  // strobe and select idle high so no false edge comes out of reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= 3'h7;
      sync_reg <= 3'h7;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pin_out = sync_reg;
endmodule : pin_sync

// ### rtl/three_wire_serial_host_port.sv
// Purpose: bit-serial host access port, command byte plus data bytes
// Assumes: mclk 250 MHz; strobe period far longer than sync latency
// Notes: control bytes and storage bytes are held here as plain arrays
//
// Behaviour
// R01 - select low during a strobe makes the bit part of a command byte.
// R02 - select high makes the bit part of a data byte for the last command.
// R03 - select low at a strobe fall mid data byte drops that byte.
// R04 - each strobe pulse moves exactly one bit on the data pin.
// R05 - in a read the device drives the next bit after the strobe falls.
// R06 - after the strobe rises in a read the device releases the pin.
// R07 - in a write the device captures the bit on the strobe rising edge.
// R08 - written data is committed only once a whole byte has arrived.
// R09 - each access command holds the byte address beside its code.
// R10 - bits go least significant first; the counter clears per byte.
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module three_wire_serial_host_port (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host link pins
  input wire logic data_strobe_n,
  input wire logic byte_type_select,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  // command register view
  output serial_port_pkg::byte_t command_byte_register,
  output logic command_valid
);
  import serial_port_pkg::*;

  logic [2:0] pins_sync;
  logic strobe_s;
  logic select_s;
  logic data_s;

  pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_in({data_in, byte_type_select, data_strobe_n}),
    .pin_out(pins_sync)
  );
  assign strobe_s = pins_sync[0];
  assign select_s = pins_sync[1];
  assign data_s = pins_sync[2];

  byte_t ctrl_mem [`CTRL_BYTES];
  byte_t ram_mem [`RAM_BYTES];

  logic strobe_d_reg;
  logic strobe_d_next;
  logic cmd_sel_reg;
  logic cmd_sel_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  byte_t shift_reg;
  byte_t shift_next;
  byte_t cmd_reg;
  byte_t cmd_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  access_e acc_reg;
  access_e acc_next;
  logic ram_sel_reg;
  logic ram_sel_next;
  addr_t addr_reg;
  addr_t addr_next;
  logic dout_reg;
  logic dout_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic commit;
  byte_t rd_byte;
  logic fall;
  logic rise;

  function automatic access_e decode_access(input logic [2:0] code);
    case (code)
      `CMD_READ_CTRL, `CMD_READ_RAM: decode_access = ACC_READ;
      `CMD_WRITE_CTRL, `CMD_WRITE_RAM: decode_access = ACC_WRITE;
      default: decode_access = ACC_NONE;
    endcase
  endfunction : decode_access

  function automatic byte_t fetch(input logic ram, input addr_t a);
    fetch = `BYTE_RESET;
    if (ram) begin
      fetch = ram_mem[a];
    end else if (a < 5'(`CTRL_BYTES)) begin
      fetch = ctrl_mem[a];
    end
  endfunction : fetch

  assign fall = strobe_d_reg && !strobe_s;
  assign rise = !strobe_d_reg && strobe_s;
  assign rd_byte = fetch(ram_sel_reg, addr_reg);

  always_comb begin
    strobe_d_next = strobe_s;
    cmd_sel_next = cmd_sel_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    cmd_valid_next = 1'b0;
    acc_next = acc_reg;
    ram_sel_next = ram_sel_reg;
    addr_next = addr_reg;
    dout_next = dout_reg;
    oe_n_next = oe_n_reg;
    commit = 1'b0;
    if (fall) begin
      // a change of byte type mid byte resynchronises the counter
      if (select_s != !cmd_sel_reg && bit_cnt_reg != 3'h0) begin
        bit_cnt_next = 3'h0; // [R03] [R10]
      end
      cmd_sel_next = !select_s; // [R01] [R02]
      if (select_s && acc_reg == ACC_READ) begin
        dout_next = rd_byte[bit_cnt_next]; // [R05] [R10]
        oe_n_next = 1'b0; // [R05]
      end
    end
    if (rise) begin
      oe_n_next = 1'b1; // [R06]
      shift_next = {data_s, shift_reg[7:1]}; // [R07] [R10] [R04]
      bit_cnt_next = bit_cnt_reg + 3'h1; // [R04]
      if (bit_cnt_reg == `BIT_COUNT_LAST) begin
        bit_cnt_next = 3'h0; // [R10]
        if (cmd_sel_reg) begin
          cmd_next = shift_next; // [R01]
          cmd_valid_next = 1'b1;
          acc_next = decode_access(
            shift_next[`CMD_FIELD_MSB:`CMD_FIELD_LSB]);
          ram_sel_next = shift_next[`CMD_FIELD_LSB + 1]; // [R09]
          addr_next = shift_next[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB]; // [R09]
        end else begin
          commit = (acc_reg == ACC_WRITE); // [R08] [R02]
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      strobe_d_reg <= 1'b1;
      cmd_sel_reg <= 1'b1;
      bit_cnt_reg <= 3'h0;
      shift_reg <= `BYTE_RESET;
      cmd_reg <= `BYTE_RESET;
      cmd_valid_reg <= 1'b0;
      acc_reg <= ACC_NONE;
      ram_sel_reg <= 1'b0;
      addr_reg <= 5'h00;
      dout_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      strobe_d_reg <= strobe_d_next;
      cmd_sel_reg <= cmd_sel_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      cmd_valid_reg <= cmd_valid_next;
      acc_reg <= acc_next;
      ram_sel_reg <= ram_sel_next;
      addr_reg <= addr_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // storage has no reset, like the documented byte store
  always_ff @(posedge mclk) begin
    if (commit) begin
      if (ram_sel_reg) begin
        ram_mem[addr_reg] <= shift_next; // [R08]
      end else if (addr_reg < 5'(`CTRL_BYTES)) begin
        ctrl_mem[addr_reg] <= shift_next; // [R08]
      end
    end
  end

  assign data_out = dout_reg;
  assign data_oe_n = oe_n_reg;
  assign command_byte_register = cmd_reg;
  assign command_valid = cmd_valid_reg;

  property p_release;
    @(posedge mclk) disable iff (rst) rise |=> data_oe_n;
  endproperty
  AST_RELEASE: assert property (p_release) // [R06]
    else $error("data pin not released after strobe rise");

  sequence s_read_fall;
    fall && select_s && acc_reg == ACC_READ;
  endsequence
  AST_DRIVE: assert property (@(posedge mclk) // [R05]
    disable iff (rst)
    s_read_fall |=> !data_oe_n)
    else $error("read bit not driven after strobe fall");
  AST_NO_DRIVE_CMD: assert property (@(posedge mclk) // [R01]
    disable iff (rst)
    (fall && !select_s) |=> data_oe_n)
    else $error("pin driven during command bit");
  AST_ONE_BIT: assert property (@(posedge mclk) // [R04]
    disable iff (rst)
    (rise && bit_cnt_reg != 3'h7)
    |=> bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
    else $error("bit counter did not step by one");
  AST_ABORT: assert property (@(posedge mclk) // [R03]
    disable iff (rst)
    (fall && !select_s && !cmd_sel_reg && bit_cnt_reg != 3'h0)
    |=> bit_cnt_reg == 3'h0 && cmd_sel_reg)
    else $error("partial data byte not dropped");
  AST_CMD_LOAD: assert property (@(posedge mclk) // [R01]
    disable iff (rst)
    (rise && cmd_sel_reg && bit_cnt_reg == 3'h7)
    |=> command_valid
    && command_byte_register == {$past(data_s), $past(shift_reg[7:1])})
    else $error("command byte not loaded");
  AST_PARTIAL: assert property (@(posedge mclk) // [R08]
    disable iff (rst)
    commit |-> bit_cnt_reg == 3'h7 && rise)
    else $error("commit on partial byte");
  AST_ADDR: assert property (@(posedge mclk) // [R09]
    disable iff (rst)
    command_valid |-> addr_reg == command_byte_register[4:0])
    else $error("address field not taken from command");
  AST_COUNT_CLR: assert property (@(posedge mclk) // [R10]
    disable iff (rst)
    (rise && bit_cnt_reg == 3'h7) |=> bit_cnt_reg == 3'h0)
    else $error("bit counter not cleared at byte end");
endmodule : three_wire_serial_host_port

// ### verification/host_model.sv
// Purpose: host side of the three-wire link, one bit per strobe pulse
// Assumes: 68 ns per bit, strobe low 8 mclk and high 9 mclk
// Notes: a released data line shows bit_reg, the host's current bit, when drive is set, and the inverse of bit_reg in reads
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk,
  // device data pin
  input wire logic data_out,
  input wire logic data_oe_n,
  // link pins to the device
  output logic data_strobe_n,
  output logic byte_type_select,
  output logic data_in
);
  import serial_port_pkg::*;
  logic drv_reg = 1'b0;
  logic bit_reg = 1'b0;
  initial begin
    data_strobe_n = 1'b1;
    byte_type_select = 1'b0;
  end
  // floating line must not echo the old level
  always_comb data_in = !data_oe_n ? data_out : (drv_reg ? bit_reg : ~bit_reg);
  task automatic xfer(input logic sel, input byte_t wr, input logic drive,
                      input int n, output byte_t rd, output byte_t oe_rd,
                      output byte_t oe_rel);
    rd = 8'h00;
    oe_rd = 8'h00;
    oe_rel = 8'hFF;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      byte_type_select <= sel;
      bit_reg <= wr[i];
      drv_reg <= drive;
      data_strobe_n <= 1'b0;
      repeat (8) @(posedge mclk);
      rd[i] = data_out;
      oe_rd[i] = data_oe_n;
      // bit held through the rising edge
      data_strobe_n <= 1'b1;
      repeat (8) @(posedge mclk);
      oe_rel[i] = data_oe_n;
      drv_reg <= 1'b0;
    end
  endtask : xfer
endmodule : host_model

// ### verification/test_three_wire_serial_host_port.sv
// Purpose: self-checking bench for the serial host port
// Assumes: host_model drives the link at 68 ns per bit
// Notes: an lfsr seeds addresses and data
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module test_three_wire_serial_host_port;
  import serial_port_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic strobe_n, sel, din, dout, oe_n, cvalid;
  byte_t cbr, rd, oe_rd, oe_rel;
  int err_total = 0;
  int comparisons = 0;
  int pulses = 0;
  logic [31:0] seed = 32'hED59;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (cvalid === 1'b1) pulses <= pulses + 1;
  three_wire_serial_host_port dut (.mclk(mclk), .rst(rst),
    .data_strobe_n(strobe_n), .byte_type_select(sel), .data_in(din),
    .data_out(dout), .data_oe_n(oe_n), .command_byte_register(cbr),
    .command_valid(cvalid));
  host_model host (.mclk(mclk), .data_out(dout), .data_oe_n(oe_n),
    .data_strobe_n(strobe_n), .byte_type_select(sel), .data_in(din));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input byte_t got, input byte_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic cmd(input logic [2:0] code, input addr_t a);
    int p;
    p = pulses;
    host.xfer(1'b0, {code, a}, 1'b1, 8, rd, oe_rd, oe_rel);
    chk(cbr, {code, a});
    chk(8'(pulses - p), 8'h01);
  endtask : cmd
  task automatic wrb(input byte_t d);
    host.xfer(1'b1, d, 1'b1, 8, rd, oe_rd, oe_rel);
  endtask : wrb
  task automatic rdb(input byte_t exp);
    host.xfer(1'b1, 8'h00, 1'b0, 8, rd, oe_rd, oe_rel);
    chk(rd, exp);
    chk(oe_rd, 8'h00);
    chk(oe_rel, 8'hFF);
  endtask : rdb
  initial begin
    byte_t d;
    addr_t a;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(cbr, `BYTE_RESET);
    chk({7'h00, oe_n}, 8'h01);
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      d = (k == 0) ? 8'h80 : seed[7:0];
      a = (k == 0) ? 5'h1F : seed[12:8];
      cmd(`CMD_WRITE_RAM, a);
      wrb(d);
      cmd(`CMD_READ_RAM, a);
      rdb(d);
      a = 5'(a % 17);
      cmd(`CMD_WRITE_CTRL, a);
      wrb(~d);
      cmd(`CMD_READ_CTRL, a);
      rdb(~d);
    end
    // partial byte, then select low aborts it
    cmd(`CMD_WRITE_CTRL, a);
    host.xfer(1'b1, d, 1'b1, 5, rd, oe_rd, oe_rel);
    cmd(`CMD_READ_CTRL, a);
    rdb(~d);
    // an unknown command code must not reach storage
    cmd(3'h5, a);
    wrb(d);
    cmd(`CMD_READ_CTRL, a);
    rdb(~d);
    cmd(`CMD_READ_CTRL, 5'h14);
    rdb(8'h00);
    results();
  end
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule : test_three_wire_serial_host_port
